// File: include/rph_pkg.sv
package rph_pkg;
  // How it works
  // - fifo threshold is six-bit field plus one
  // - rx threshold flag when count at/above threshold
  // - tx threshold flag when count at/below threshold
  // - coding bit seven selects manchester payload coding
  // - length field: fixed size or variable maximum
  // - variable length byte above maximum discards packet
  // - node address register identifies this radio
  // - format bit seven: fixed zero, variable one
  // - preamble bytes equal two-bit field plus one
  // - scrambling bit four whitens tx, dewhitens rx
  // - crc enable bit three adds and checks crc
  // - address filter codes: 01 accepts node only, 10 adds 00 broadcast, 11 adds ff
  // - status bit zero holds last crc result
  // - crc filter zero clears fifo on crc error
  // - standby access bit: zero write, one read
  // - not-empty low ends tx, full marks rx
  // - three-bit mode field selects sleep to transmit
  // - buffered clock output stops in sleep
  // - mapping register picks source per interrupt line
  // - two-bit size field sets 16 to 64 bytes
  // - rx fifo receives payload only, no preamble
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_FIFO_CFG = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_MAP = 5'h0d;
  localparam logic [4:0] ADDR_CODING = 5'h1c;
  localparam logic [4:0] ADDR_NODE = 5'h1d;
  localparam logic [4:0] ADDR_FORMAT = 5'h1e;
  localparam logic [4:0] ADDR_ACCESS = 5'h1f;
  localparam logic [7:0] RST_MODE = 8'h20;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam int MODE_LSB = 5;
  localparam int SIZE_LSB = 6;
  localparam int MANCH_BIT = 7;
  localparam int VAR_BIT = 7;
  localparam int PRE_LSB = 5;
  localparam int SCR_BIT = 4;
  localparam int CRC_EN_BIT = 3;
  localparam int FILT_LSB = 1;
  localparam int CRC_OK_BIT = 0;
  localparam int CRC_KEEP_BIT = 7;
  localparam int SBY_READ_BIT = 6;
  localparam int IRQ_A_LSB = 6;
  localparam int IRQ_B_LSB = 4;
  localparam int IRQ_TX_BIT = 3;
  localparam int CMD_READ_BIT = 7;
  localparam int FIFO_UNIT = 16;
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_RX = 3'h3;
  localparam logic [2:0] MODE_TX = 3'h4;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] BCAST_LO = 8'h00;
  localparam logic [7:0] BCAST_HI = 8'hff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [8:0] WHITEN_SEED = 9'h1ff;
  localparam logic [4:0] LINK_CMD_END = 5'h07;
  localparam logic [4:0] LINK_WR_END = 5'h0f;
  localparam logic [4:0] LINK_RD_END = 5'h17;
  typedef struct packed {
    logic is_cfg;
    logic rd;
    logic [4:0] addr;
    logic [7:0] data;
  } rph_req_s;
  typedef enum logic [2:0] {T_IDLE, T_PRE, T_BODY, T_CRC_HI, T_CRC_LO, T_DONE} rph_tx_e;
  typedef enum logic [2:0] {R_IDLE, R_BODY, R_CRC_HI, R_CRC_LO, R_DONE} rph_rx_e;
endpackage

// File: core/rph_packet_handler.sv
`timescale 1ns/100ps
module rph_packet_handler #(
  parameter int FIFO_MAX = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_sck,
  input wire logic config_select_n,
  input wire logic data_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic rx_chip,
  input wire logic rx_chip_valid,
  input wire logic rx_start_found,
  input wire logic tx_chip_req,
  output logic tx_chip,
  output logic interrupt_line_a,
  output logic interrupt_line_b,
  output logic buffer_not_empty_n,
  output logic buffer_full_flag,
  output logic xtal_en,
  output logic pll_en,
  output logic rx_en,
  output logic tx_en,
  output logic clk_out
);
  localparam int PW = $clog2(FIFO_MAX);

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ rph_pkg::CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // link side, clocked by the host serial clock
  logic lrst_s1_r, lrst_s2_r, ack_s1_r, ack_s2_r;
  logic [4:0] lcnt_r, lcnt_nxt;
  logic [7:0] lsh_r, lsh_nxt, lout_r, lout_nxt;
  logic lcfg_r, lcfg_nxt, lrd_r, lrd_nxt, ltgl_r, ltgl_nxt, loe_r, loe_nxt;
  logic [4:0] laddr_r, laddr_nxt;
  rph_pkg::rph_req_s lreq_r, lreq_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  // handover toggle flops, declared here because the link side reads the core's copy
  logic rq_s1_r, rq_s2_r, rq_seen_r;

  always_comb begin
    lcnt_nxt = lcnt_r;
    lsh_nxt = {lsh_r[6:0], serial_in};
    lcfg_nxt = lcfg_r;
    lrd_nxt = lrd_r;
    laddr_nxt = laddr_r;
    lreq_nxt = lreq_r;
    ltgl_nxt = ltgl_r;
    lout_nxt = {lout_r[6:0], 1'b0};
    loe_nxt = loe_r;
    if (lrst_s2_r) begin
      lcnt_nxt = '0;
      ltgl_nxt = 1'b0;
      loe_nxt = 1'b0;
    end else if (config_select_n && data_select_n) begin
      lcnt_nxt = '0;
      loe_nxt = 1'b0;
    end else begin
      lcnt_nxt = lcnt_r + 5'h01;
      if (lcnt_r == '0) begin
        lcfg_nxt = !config_select_n;
      end
      if (lcnt_r == rph_pkg::LINK_CMD_END) begin
        lrd_nxt = lsh_nxt[rph_pkg::CMD_READ_BIT];
        laddr_nxt = lsh_nxt[4:0];
        if (lsh_nxt[rph_pkg::CMD_READ_BIT]) begin
          lreq_nxt = '{is_cfg: lcfg_r, rd: 1'b1, addr: lsh_nxt[4:0], data: 8'h00};
          ltgl_nxt = !ltgl_r;
        end
      end
      if (lcnt_r == rph_pkg::LINK_WR_END) begin
        if (!lrd_r) begin
          lreq_nxt = '{is_cfg: lcfg_r, rd: 1'b0, addr: laddr_r, data: lsh_nxt};
          ltgl_nxt = !ltgl_r;
          lcnt_nxt = '0;
        end else begin
          // answer is stable once the ack toggle has come back
          lout_nxt = (ack_s2_r == ltgl_r) ? rd_data_r : 8'hff;
          loe_nxt = 1'b1;
        end
      end
      if (lcnt_r == rph_pkg::LINK_RD_END) begin
        lcnt_nxt = '0;
        loe_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge link_sck) begin
    lrst_s1_r <= rst;
    lrst_s2_r <= lrst_s1_r;
    ack_s1_r <= rq_seen_r;
    ack_s2_r <= ack_s1_r;
    lcnt_r <= lcnt_nxt;
    lsh_r <= lsh_nxt;
    lcfg_r <= lcfg_nxt;
    lrd_r <= lrd_nxt;
    laddr_r <= laddr_nxt;
    lreq_r <= lreq_nxt;
    ltgl_r <= ltgl_nxt;
    lout_r <= lout_nxt;
    loe_r <= loe_nxt;
  end
  assign serial_out = lout_r[7];
  assign serial_out_oe = loe_r;

  // core side
  logic [7:0] mode_cfg_r, mode_cfg_nxt, fifo_cfg_r, fifo_cfg_nxt, irq_map_r, irq_map_nxt;
  logic [7:0] coding_r, coding_nxt, node_r, node_nxt, format_r, format_nxt;
  logic [7:0] access_r, access_nxt, reg_rd;
  logic [7:0] mem_r [FIFO_MAX];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt, depth, thr;
  logic push, pop, fifo_clr, wr_pulse, empty, full, host_wr_ok, host_rd_ok;
  logic [7:0] push_data, head, b;
  logic [2:0] mode;
  logic scr, manch, crc_en, is_var, coded, man, dbit, adv, last_nxt, addr_pos, addr_ok;
  rph_pkg::rph_tx_e tst_r, tst_nxt;
  logic [7:0] tbyte_r, tbyte_nxt, trem_r, trem_nxt;
  logic [2:0] tbit_r, tbit_nxt;
  logic [1:0] tpre_r, tpre_nxt;
  logic thalf_r, thalf_nxt, tfirst_r, tfirst_nxt, tlast_r, tlast_nxt, tstop_r, tstop_nxt;
  logic tchip_r, tchip_nxt;
  logic [8:0] tlfsr_r, tlfsr_nxt, rlfsr_r, rlfsr_nxt;
  logic [15:0] tcrc_r, tcrc_nxt, rcrc_r, rcrc_nxt;
  rph_pkg::rph_rx_e rst_r, rst_nxt;
  logic [7:0] rbyte_r, rbyte_nxt, rrem_r, rrem_nxt, rhi_r, rhi_nxt;
  logic [2:0] rbit_r, rbit_nxt;
  logic [1:0] ridx_r, ridx_nxt;
  logic rhalf_r, rhalf_nxt, rhold_r, rhold_nxt, rdy_r, rdy_nxt, match_r, match_nxt;
  logic irq_a_r, irq_a_nxt, irq_b_r, irq_b_nxt, ne_r, full_r, ck_r;

  assign mode = mode_cfg_r[rph_pkg::MODE_LSB +: 3];
  assign depth = (PW+1)'((int'(fifo_cfg_r[rph_pkg::SIZE_LSB +: 2]) + 1) * rph_pkg::FIFO_UNIT);
  assign thr = (PW+1)'(int'(fifo_cfg_r[5:0]) + 1);
  assign empty = (cnt_r == '0);
  assign full = (cnt_r >= depth);
  assign head = mem_r[rp_r];
  assign scr = format_r[rph_pkg::SCR_BIT];
  assign manch = coding_r[rph_pkg::MANCH_BIT];
  assign crc_en = format_r[rph_pkg::CRC_EN_BIT];
  assign is_var = format_r[rph_pkg::VAR_BIT];
  assign host_wr_ok = (mode == rph_pkg::MODE_TX) ||
                      (mode == rph_pkg::MODE_STBY && !access_r[rph_pkg::SBY_READ_BIT]);
  assign host_rd_ok = (mode == rph_pkg::MODE_RX) ||
                      (mode == rph_pkg::MODE_STBY && access_r[rph_pkg::SBY_READ_BIT]);

  always_comb begin
    case (lreq_r.addr)
      rph_pkg::ADDR_MODE: reg_rd = mode_cfg_r;
      rph_pkg::ADDR_FIFO_CFG: reg_rd = fifo_cfg_r;
      rph_pkg::ADDR_IRQ_MAP: reg_rd = irq_map_r;
      rph_pkg::ADDR_CODING: reg_rd = coding_r;
      rph_pkg::ADDR_NODE: reg_rd = node_r;
      rph_pkg::ADDR_FORMAT: reg_rd = format_r;
      rph_pkg::ADDR_ACCESS: reg_rd = access_r;
      default: reg_rd = 8'h00;
    endcase
  end

  always_comb begin
    {mode_cfg_nxt, fifo_cfg_nxt, irq_map_nxt} = {mode_cfg_r, fifo_cfg_r, irq_map_r};
    {coding_nxt, node_nxt, format_nxt, access_nxt} = {coding_r, node_r, format_r, access_r};
    rd_data_nxt = rd_data_r;
    push = 1'b0;
    pop = 1'b0;
    push_data = 8'h00;
    fifo_clr = 1'b0;
    wr_pulse = 1'b0;
    {tst_nxt, tbyte_nxt, trem_nxt, tbit_nxt, tpre_nxt} = {tst_r, tbyte_r, trem_r, tbit_r, tpre_r};
    {thalf_nxt, tfirst_nxt, tlast_nxt, tstop_nxt, tchip_nxt} =
      {thalf_r, tfirst_r, tlast_r, tstop_r, tchip_r};
    {tlfsr_nxt, tcrc_nxt, rlfsr_nxt, rcrc_nxt} = {tlfsr_r, tcrc_r, rlfsr_r, rcrc_r};
    {rst_nxt, rbyte_nxt, rrem_nxt, rhi_nxt, rbit_nxt, ridx_nxt} =
      {rst_r, rbyte_r, rrem_r, rhi_r, rbit_r, ridx_r};
    {rhalf_nxt, rhold_nxt, rdy_nxt, match_nxt} = {rhalf_r, rhold_r, rdy_r, match_r};
    coded = 1'b0;
    man = 1'b0;
    dbit = 1'b0;
    adv = 1'b0;
    last_nxt = 1'b0;
    b = 8'h00;
    addr_pos = 1'b0;
    addr_ok = 1'b0;
    // host requests, handed over by toggle
    if (rq_s2_r != rq_seen_r) begin
      if (lreq_r.is_cfg && lreq_r.rd) begin
        rd_data_nxt = reg_rd;
      end else if (lreq_r.is_cfg) begin
        case (lreq_r.addr)
          rph_pkg::ADDR_MODE: mode_cfg_nxt = lreq_r.data;
          rph_pkg::ADDR_FIFO_CFG: fifo_cfg_nxt = lreq_r.data;
          rph_pkg::ADDR_IRQ_MAP: irq_map_nxt = lreq_r.data;
          rph_pkg::ADDR_CODING: coding_nxt = lreq_r.data;
          rph_pkg::ADDR_NODE: node_nxt = lreq_r.data;
          rph_pkg::ADDR_FORMAT: format_nxt = {lreq_r.data[7:1], format_r[rph_pkg::CRC_OK_BIT]};
          rph_pkg::ADDR_ACCESS: access_nxt = lreq_r.data;
          default: ;
        endcase
      end else if (lreq_r.rd) begin
        rd_data_nxt = 8'h00;
        if (host_rd_ok && !empty) begin
          pop = 1'b1;
          rd_data_nxt = head;
        end
      end else if (host_wr_ok && !full) begin
        push = 1'b1;
        push_data = lreq_r.data;
      end
    end
    // transmit path
    if (mode != rph_pkg::MODE_TX) begin
      tst_nxt = rph_pkg::T_IDLE;
      tstop_nxt = 1'b0;
    end else if (tst_r == rph_pkg::T_IDLE) begin
      tst_nxt = rph_pkg::T_PRE;
      tbyte_nxt = rph_pkg::PREAMBLE_BYTE;
      tpre_nxt = format_r[rph_pkg::PRE_LSB +: 2];
      {tbit_nxt, thalf_nxt, tlast_nxt} = '0;
      tfirst_nxt = 1'b1;
      trem_nxt = is_var ? 8'h01 : {1'b0, coding_r[6:0]};
      tlfsr_nxt = rph_pkg::WHITEN_SEED;
      tcrc_nxt = rph_pkg::CRC_INIT;
    end else if (tst_r != rph_pkg::T_DONE && tx_chip_req) begin
      coded = (tst_r != rph_pkg::T_PRE);
      dbit = tbyte_r[3'd7 - tbit_r] ^ (coded & scr & tlfsr_r[0]);
      man = coded & manch;
      tchip_nxt = (man & thalf_r) ? !dbit : dbit;
      adv = !man | thalf_r;
      thalf_nxt = man & !thalf_r;
      if (tlast_r && tbit_r == 3'd7 && !thalf_r) begin
        tstop_nxt = 1'b1;
      end
      if (adv) begin
        tbit_nxt = tbit_r + 3'd1;
        if (coded && scr) begin
          tlfsr_nxt = {tlfsr_r[0] ^ tlfsr_r[5], tlfsr_r[8:1]};
        end
        if (tbit_r == 3'd7) begin
          if (tst_r == rph_pkg::T_PRE && tpre_r != 2'd0) begin
            tpre_nxt = tpre_r - 2'd1;
          end else if ((tst_r == rph_pkg::T_PRE || tst_r == rph_pkg::T_BODY) && trem_r != '0) begin
            if (empty) begin
              tst_nxt = rph_pkg::T_DONE;
              tstop_nxt = 1'b1;
            end else begin
              pop = 1'b1;
              tbyte_nxt = head;
              tcrc_nxt = crc_upd(tcrc_r, head);
              trem_nxt = (tfirst_r && is_var) ? head : trem_r - 8'd1;
              tfirst_nxt = 1'b0;
              tlast_nxt = (trem_nxt == '0) && !crc_en;
              tst_nxt = rph_pkg::T_BODY;
            end
          end else if (crc_en && tst_r != rph_pkg::T_CRC_HI && tst_r != rph_pkg::T_CRC_LO) begin
            tbyte_nxt = tcrc_r[15:8];
            tst_nxt = rph_pkg::T_CRC_HI;
          end else if (tst_r == rph_pkg::T_CRC_HI) begin
            tbyte_nxt = tcrc_r[7:0];
            tlast_nxt = 1'b1;
            tst_nxt = rph_pkg::T_CRC_LO;
          end else begin
            tst_nxt = rph_pkg::T_DONE;
          end
        end
      end
    end
    // receive path: the modem has already consumed preamble and start pattern
    if (mode != rph_pkg::MODE_RX) begin
      rst_nxt = rph_pkg::R_IDLE;
      rdy_nxt = 1'b0;
      match_nxt = 1'b0;
    end else if (rx_start_found && (rst_r == rph_pkg::R_IDLE || rst_r == rph_pkg::R_DONE)) begin
      rst_nxt = rph_pkg::R_BODY;
      {rbit_nxt, ridx_nxt, rhalf_nxt, rdy_nxt} = '0;
      match_nxt = 1'b1;
      rrem_nxt = {1'b0, coding_r[6:0]};
      rlfsr_nxt = rph_pkg::WHITEN_SEED;
      rcrc_nxt = rph_pkg::CRC_INIT;
    end else if (rx_chip_valid && rst_r != rph_pkg::R_IDLE && rst_r != rph_pkg::R_DONE) begin
      if (manch && !rhalf_r) begin
        rhold_nxt = rx_chip;
        rhalf_nxt = 1'b1;
      end else begin
        rhalf_nxt = 1'b0;
        dbit = (manch ? rhold_r : rx_chip) ^ (scr & rlfsr_r[0]);
        if (scr) begin
          rlfsr_nxt = {rlfsr_r[0] ^ rlfsr_r[5], rlfsr_r[8:1]};
        end
        rbyte_nxt = {rbyte_r[6:0], dbit};
        rbit_nxt = rbit_r + 3'd1;
        b = rbyte_nxt;
        if (rbit_r == 3'd7) begin
          if (rst_r == rph_pkg::R_BODY) begin
            rcrc_nxt = crc_upd(rcrc_r, b);
            addr_pos = (format_r[rph_pkg::FILT_LSB +: 2] != 2'b00) && (ridx_r == {1'b0, is_var});
            addr_ok = (b == node_r) ||
                      (format_r[rph_pkg::FILT_LSB +: 2] >= 2'b10 && b == rph_pkg::BCAST_LO) ||
                      (format_r[rph_pkg::FILT_LSB +: 2] == 2'b11 && b == rph_pkg::BCAST_HI);
            if ((is_var && ridx_r == 2'd0 && b > {1'b0, coding_r[6:0]}) ||
                (addr_pos && !addr_ok)) begin
              fifo_clr = 1'b1;
              rst_nxt = rph_pkg::R_IDLE;
            end else begin
              push = !full;
              push_data = b;
              wr_pulse = 1'b1;
              rrem_nxt = (is_var && ridx_r == 2'd0) ? b : rrem_r - 8'd1;
              if (ridx_r != 2'd3) begin
                ridx_nxt = ridx_r + 2'd1;
              end
              if (rrem_nxt == '0) begin
                rst_nxt = crc_en ? rph_pkg::R_CRC_HI : rph_pkg::R_DONE;
                rdy_nxt = !crc_en;
              end
            end
          end else if (rst_r == rph_pkg::R_CRC_HI) begin
            rhi_nxt = b;
            rst_nxt = rph_pkg::R_CRC_LO;
          end else begin
            last_nxt = ({rhi_r, b} == rcrc_r);
            format_nxt[rph_pkg::CRC_OK_BIT] = last_nxt;
            fifo_clr = !last_nxt && !access_r[rph_pkg::CRC_KEEP_BIT];
            rdy_nxt = last_nxt;
            rst_nxt = rph_pkg::R_DONE;
          end
        end
      end
    end
    // interrupt line routing per mode, from packet events and the current fifo occupancy
    irq_a_nxt = 1'b0;
    irq_b_nxt = 1'b0;
    if (mode == rph_pkg::MODE_RX) begin
      case (irq_map_r[rph_pkg::IRQ_A_LSB +: 2])
        2'b00: irq_a_nxt = rdy_r;
        2'b01: irq_a_nxt = wr_pulse;
        2'b10: irq_a_nxt = !empty;
        default: irq_a_nxt = match_r;
      endcase
      case (irq_map_r[rph_pkg::IRQ_B_LSB +: 2])
        2'b00: irq_b_nxt = format_r[rph_pkg::CRC_OK_BIT];
        2'b01: irq_b_nxt = full;
        2'b10: irq_b_nxt = 1'b0; // signal strength lives outside this block
        default: irq_b_nxt = (cnt_r >= thr);
      endcase
    end else if (mode == rph_pkg::MODE_TX) begin
      irq_a_nxt = irq_map_r[rph_pkg::IRQ_TX_BIT] ? (cnt_r <= thr) : !empty;
      irq_b_nxt = irq_map_r[rph_pkg::IRQ_TX_BIT] ? tstop_r : full;
    end
  end

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    if (push) begin
      wp_nxt = (wp_r == PW'(depth - 1'b1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == PW'(depth - 1'b1)) ? '0 : rp_r + 1'b1;
    end
    if (fifo_clr) begin
      // a discard wins over a byte landing in the same cycle
      {wp_nxt, rp_nxt, cnt_nxt} = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !fifo_clr) begin
      mem_r[wp_r] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    rq_s1_r <= ltgl_r;
    rq_s2_r <= rq_s1_r;
    if (rst) begin
      rq_seen_r <= 1'b0;
      {mode_cfg_r, fifo_cfg_r} <= {rph_pkg::RST_MODE, rph_pkg::RST_OTHER};
      {irq_map_r, coding_r, node_r} <= {3{rph_pkg::RST_OTHER}};
      {format_r, access_r, rd_data_r} <= {3{rph_pkg::RST_OTHER}};
      {wp_r, rp_r, cnt_r} <= '0;
      tst_r <= rph_pkg::T_IDLE;
      rst_r <= rph_pkg::R_IDLE;
      {tbyte_r, trem_r, tbit_r, tpre_r, thalf_r, tfirst_r, tlast_r, tstop_r, tchip_r} <= '0;
      {tlfsr_r, tcrc_r, rlfsr_r, rcrc_r} <= '0;
      {rbyte_r, rrem_r, rhi_r, rbit_r, ridx_r, rhalf_r, rhold_r, rdy_r, match_r} <= '0;
      {irq_a_r, irq_b_r, ne_r, full_r, ck_r} <= '0;
      {xtal_en, pll_en, rx_en, tx_en} <= '0;
    end else begin
      rq_seen_r <= rq_s2_r;
      {mode_cfg_r, fifo_cfg_r, irq_map_r} <= {mode_cfg_nxt, fifo_cfg_nxt, irq_map_nxt};
      {coding_r, node_r, format_r, access_r} <= {coding_nxt, node_nxt, format_nxt, access_nxt};
      rd_data_r <= rd_data_nxt;
      {wp_r, rp_r, cnt_r} <= {wp_nxt, rp_nxt, cnt_nxt};
      tst_r <= tst_nxt;
      rst_r <= rst_nxt;
      {tbyte_r, trem_r, tbit_r, tpre_r} <= {tbyte_nxt, trem_nxt, tbit_nxt, tpre_nxt};
      {thalf_r, tfirst_r, tlast_r, tstop_r, tchip_r} <=
        {thalf_nxt, tfirst_nxt, tlast_nxt, tstop_nxt, tchip_nxt};
      {tlfsr_r, tcrc_r, rlfsr_r, rcrc_r} <= {tlfsr_nxt, tcrc_nxt, rlfsr_nxt, rcrc_nxt};
      {rbyte_r, rrem_r, rhi_r, rbit_r, ridx_r} <= {rbyte_nxt, rrem_nxt, rhi_nxt, rbit_nxt, ridx_nxt};
      {rhalf_r, rhold_r, rdy_r, match_r} <= {rhalf_nxt, rhold_nxt, rdy_nxt, match_nxt};
      {irq_a_r, irq_b_r} <= {irq_a_nxt, irq_b_nxt};
      ne_r <= (cnt_nxt != '0);
      full_r <= (cnt_nxt >= depth);
      ck_r <= (mode == rph_pkg::MODE_SLEEP) ? 1'b0 : !ck_r;
      xtal_en <= (mode != rph_pkg::MODE_SLEEP);
      pll_en <= (mode == rph_pkg::MODE_SYNTH) || (mode == rph_pkg::MODE_RX) ||
                (mode == rph_pkg::MODE_TX);
      rx_en <= (mode == rph_pkg::MODE_RX);
      tx_en <= (mode == rph_pkg::MODE_TX);
    end
  end

  assign tx_chip = tchip_r;
  assign interrupt_line_a = irq_a_r;
  assign interrupt_line_b = irq_b_r;
  assign buffer_not_empty_n = ne_r;
  assign buffer_full_flag = full_r;
  assign clk_out = ck_r;
endmodule

// File: tb/rph_checker.sv
`timescale 1ns/100ps
module rph_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_sck,
  input wire logic config_select_n,
  input wire logic data_select_n,
  input wire logic serial_out_oe,
  input wire logic tx_chip_req,
  input wire logic tx_chip,
  input wire logic buffer_not_empty_n,
  input wire logic buffer_full_flag,
  input wire logic xtal_en,
  input wire logic pll_en,
  input wire logic rx_en,
  input wire logic tx_en,
  input wire logic clk_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // settle time after entering transmit; the preamble load leaves the chip alone, only a request moves it
  sequence tx_settled_s;
    tx_en [*4] ##0 !tx_chip_req;
  endsequence
  sequence xtal_on_s;
    xtal_en [*3];
  endsequence
  sleep_all_off_a: assert property (!xtal_en |-> !(pll_en || rx_en || tx_en))
    else $error("sleep leaves a block enabled");
  radio_needs_pll_a: assert property ((rx_en || tx_en) |-> xtal_en && pll_en)
    else $error("radio on without synthesizer");
  rx_tx_excl_a: assert property (!(rx_en && tx_en))
    else $error("receive and transmit both on");
  clk_out_stop_a: assert property (!xtal_en [*2] |-> !clk_out)
    else $error("clock output runs in sleep");
  clk_out_run_a: assert property (xtal_on_s |-> clk_out != $past(clk_out))
    else $error("clock output stalled while awake");
  full_not_empty_a: assert property (buffer_full_flag |-> buffer_not_empty_n)
    else $error("full flag with empty buffer");
  chip_hold_a: assert property (tx_settled_s |=> !tx_en || $stable(tx_chip))
    else $error("chip moved without request");
  oe_in_frame_a: assert property (@(posedge link_sck) disable iff (rst)
    serial_out_oe |-> !(config_select_n && data_select_n))
    else $error("serial output driven outside a frame");
endmodule
bind rph_packet_handler rph_checker rph_checker_inst (.clk, .rst, .link_sck, .config_select_n,
  .data_select_n, .serial_out_oe, .tx_chip_req, .tx_chip, .buffer_not_empty_n,
  .buffer_full_flag, .xtal_en, .pll_en, .rx_en, .tx_en, .clk_out);

// File: tb/rph_host_model.sv
`timescale 1ns/100ps
module rph_host_model (
  output logic link_sck,
  output logic config_select_n,
  output logic data_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  logic [7:0] rd_data;
  event rd_done;
  initial begin
    link_sck = 1'b0;
    config_select_n = 1'b1;
    data_select_n = 1'b1;
    serial_in = 1'b0;
    // a few edges under reset clear the link toggle
    repeat (8) #24 link_sck = ~link_sck;
  end
  // the link sees reset only on its own edges, so a few idle edges flush it after release
  task automatic idle(input int n);
    repeat (n) begin
      #24 link_sck = 1'b1;
      #24 link_sck = 1'b0;
    end
  endtask
  task automatic xfer(input rph_pkg::rph_req_s r);
    logic [23:0] sh;
    sh = {r.rd, 2'b00, r.addr, r.data, 8'h00};
    config_select_n = !r.is_cfg;
    data_select_n = r.is_cfg;
    for (int i = 0; i < (r.rd ? 24 : 16); i++) begin
      serial_in = sh[23-i];
      #24 link_sck = 1'b1;
      #24 link_sck = 1'b0;
      if (i > 14 && i < 23) rd_data[22-i] = serial_out;
    end
    #24 config_select_n = 1'b1;
    data_select_n = 1'b1;
    serial_in = 1'b0;
    if (r.rd) ->rd_done;
  endtask
endmodule

// File: tb/test_radio_packet_handler.sv
`timescale 1ns/100ps
module test_radio_packet_handler;
  logic clk = 1'b0, rst = 1'b1, rx_chip = 1'b0, rx_chip_valid = 1'b0;
  logic rx_start_found = 1'b0, tx_chip_req = 1'b0;
  logic link_sck, config_select_n, data_select_n, serial_in, serial_out, serial_out_oe, tx_chip;
  logic interrupt_line_a, interrupt_line_b, buffer_not_empty_n, buffer_full_flag;
  logic xtal_en, pll_en, rx_en, tx_en, clk_out;
  logic [7:0] d;
  logic [7:0] exp_q[$];
  logic [7:0] pay[$];
  logic [4:0] addrs[8] = '{rph_pkg::ADDR_MODE, rph_pkg::ADDR_FIFO_CFG, rph_pkg::ADDR_IRQ_MAP,
    rph_pkg::ADDR_CODING, rph_pkg::ADDR_NODE, rph_pkg::ADDR_FORMAT, rph_pkg::ADDR_ACCESS, 5'h05};
  int failures = 0, samples_checked = 0, seed = 89;
  always #10 clk = ~clk;
  rph_packet_handler rph_packet_handler_inst (.clk, .rst, .link_sck, .config_select_n,
    .data_select_n, .serial_in, .serial_out, .serial_out_oe, .rx_chip, .rx_chip_valid,
    .rx_start_found, .tx_chip_req, .tx_chip, .interrupt_line_a, .interrupt_line_b,
    .buffer_not_empty_n, .buffer_full_flag, .xtal_en, .pll_en, .rx_en, .tx_en, .clk_out);
  rph_host_model rph_host_model_inst (.link_sck, .config_select_n, .data_select_n, .serial_in,
    .serial_out);
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] a);
    samples_checked++;
    if (a !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, a);
    end
  endtask
  always @(rph_host_model_inst.rd_done) check("read", exp_q.pop_front(), rph_host_model_inst.rd_data);
  task automatic wr(input logic c, input logic [4:0] a, input logic [7:0] v);
    rph_host_model_inst.xfer('{c, 1'b0, a, v});
    repeat (6) @(posedge clk);
  endtask
  task automatic rd(input logic c, input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    rph_host_model_inst.xfer('{c, 1'b1, a, 8'h00});
    repeat (6) @(posedge clk);
  endtask
  task automatic rx_pkt(input logic [15:0] v);
    @(posedge clk) #1 rx_start_found = 1'b1;
    @(posedge clk) #1 rx_start_found = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      {rx_chip, rx_chip_valid} = {v[k], 1'b1};
      @(posedge clk) #1 rx_chip_valid = 1'b0;
      @(posedge clk) #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #500000 failures++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    rph_host_model_inst.idle(4);
    foreach (addrs[i]) rd(1'b1, addrs[i], i == 0 ? rph_pkg::RST_MODE : 8'h00);
    for (int i = 1; i < 7; i++) begin
      d = $random(seed);
      wr(1'b1, addrs[i], d);
      rd(1'b1, addrs[i], i == 5 ? {d[7:1], 1'b0} : d);
    end
    $display("register test done");
    for (int m = 0; m < 5; m++) begin
      wr(1'b1, rph_pkg::ADDR_MODE, {m[2:0], 5'h00});
      check("mode", {4'h0, m != 0, m > 1, m == 3, m == 4}, {4'h0, xtal_en, pll_en, rx_en, tx_en});
      if (m == 0) check("clk_out", 8'h00, 8'(clk_out));
    end
    $display("mode test done");
    wr(1'b1, rph_pkg::ADDR_MODE, 8'h20);
    wr(1'b1, rph_pkg::ADDR_FIFO_CFG, 8'h00);
    wr(1'b1, rph_pkg::ADDR_ACCESS, 8'h00);
    for (int i = 0; i < 17; i++) begin
      d = $random(seed);
      if (i < 16) pay.push_back(d);
      wr(1'b0, 5'h00, d);
      check("full", 8'(i > 14), 8'(buffer_full_flag));
    end
    wr(1'b1, rph_pkg::ADDR_ACCESS, 8'h40);
    for (int i = 0; i < 17; i++) rd(1'b0, 5'h00, i < 16 ? pay[i] : 8'h00);
    check("not_empty", 8'h00, 8'(buffer_not_empty_n));
    $display("buffer test done");
    pay.delete();
    wr(1'b1, rph_pkg::ADDR_ACCESS, 8'h00);
    wr(1'b1, rph_pkg::ADDR_CODING, 8'h02);
    wr(1'b1, rph_pkg::ADDR_FORMAT, 8'h40);
    wr(1'b1, rph_pkg::ADDR_IRQ_MAP, 8'h08);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      pay.push_back(d);
      wr(1'b0, 5'h00, d);
    end
    wr(1'b1, rph_pkg::ADDR_MODE, 8'h40);
    repeat (20) @(posedge clk);
    wr(1'b1, rph_pkg::ADDR_MODE, 8'h80);
    for (int b = 0; b < 5; b++) begin
      for (int k = 7; k >= 0; k--) begin
        @(posedge clk) #1 tx_chip_req = 1'b1;
        @(posedge clk) #1 tx_chip_req = 1'b0;
        d[k] = tx_chip;
      end
      check("chip_byte", b < 3 ? rph_pkg::PREAMBLE_BYTE : pay[b-3], d);
    end
    repeat (10) @(posedge clk);
    check("tx_done", 8'h00, 8'(buffer_not_empty_n));
    check("tx_thr", 8'h01, 8'(interrupt_line_a));
    check("tx_stop", 8'h01, 8'(interrupt_line_b));
    wr(1'b1, rph_pkg::ADDR_MODE, 8'h20);
    $display("transmit test done");
    d = $random(seed);
    wr(1'b1, rph_pkg::ADDR_NODE, d);
    wr(1'b1, rph_pkg::ADDR_FORMAT, 8'h02);
    wr(1'b1, rph_pkg::ADDR_IRQ_MAP, 8'h30);
    wr(1'b1, rph_pkg::ADDR_MODE, 8'h60);
    rx_pkt({~d, 8'h3c});
    check("filtered", 8'h00, 8'(buffer_not_empty_n));
    rx_pkt({d, 8'h3c});
    check("rx_ready", 8'h01, 8'(interrupt_line_a));
    check("rx_thr", 8'h01, 8'(interrupt_line_b));
    rd(1'b0, 5'h00, d);
    rd(1'b0, 5'h00, 8'h3c);
    wr(1'b1, rph_pkg::ADDR_MODE, 8'h20);
    $display("receive test done");
    complete_run();
  end
endmodule
